//--- prcl_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module prcl_clk_div (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire prcl_pkg::prcl_div_t i_div_sel,
  output logic o_tick
);
  import prcl_pkg::*;

  logic [2:0] cnt_reg;
  logic [2:0] mask;

  // The divider runs straight off the system clock, which is the high-speed clock.
  always_comb begin
    unique case (i_div_sel)
      PRCL_DIV1: mask = 3'h0;
      PRCL_DIV2: mask = 3'h1;
      PRCL_DIV4: mask = 3'h3;
      PRCL_DIV8: mask = 3'h7;
    endcase
  end

  assign o_tick = i_run && ((cnt_reg & mask) == mask);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= PRCL_DIV_CNT_RESET[2:0];
    end else if (!i_run) begin
      cnt_reg <= 3'h0;
    end else begin
      // Restarting after every tick gives a newly loaded divisor a full first period.
      cnt_reg <= o_tick ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  property p_div1_every;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_run && i_div_sel == PRCL_DIV1) |-> o_tick;
  endproperty
  a_div1_every: assert property (p_div1_every) else $error("undivided clock missed a tick");

  property p_div8_gap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_tick && i_div_sel == PRCL_DIV8) ##1 (i_run && i_div_sel == PRCL_DIV8) [*7]
        |-> !o_tick ##1 (i_run && i_div_sel == PRCL_DIV8) |-> o_tick;
  endproperty
  a_div8_gap: assert property (p_div8_gap) else $error("divide by eight spacing wrong");

endmodule
`default_nettype wire

//--- prcl_pkg.sv
package prcl_pkg;

  localparam logic [7:0] PRCL_OFS_CTRL_LOW = 8'h40;
  localparam logic [7:0] PRCL_OFS_CTRL_HIGH = 8'h41;
  localparam logic [7:0] PRCL_OFS_IRQ_STATUS = 8'h60;
  localparam logic [7:0] PRCL_OFS_IRQ_MASK = 8'h61;

  localparam int PRCL_BIT_ENABLE = 0;
  localparam int PRCL_BIT_LOAD_OKAY = 1;
  localparam int PRCL_BIT_RSVD_LO = 2;
  localparam int PRCL_BIT_RSVD_HI = 3;
  localparam int PRCL_BIT_FLAG = 4;
  localparam int PRCL_BIT_IRQ_EN = 5;
  localparam int PRCL_BIT_DIV_LO = 6;
  localparam int PRCL_BIT_DIV_HI = 7;
  localparam int PRCL_BIT_LOAD_FREQUENCY_SELECT_LO = 4;
  localparam int PRCL_BIT_LOAD_FREQUENCY_SELECT_HI = 7;

  localparam logic [7:0] PRCL_CTRL_LOW_RESET = 8'h00;
  localparam logic [3:0] PRCL_LOAD_FREQUENCY_SELECT_RESET = 4'h0;
  localparam logic [3:0] PRCL_DIV_CNT_RESET = 4'h0;

  localparam int PRCL_EV_RELOAD = 0;
  localparam int PRCL_EV_LOADED = 1;
  localparam int PRCL_EV_W = 2;

  typedef enum logic [1:0] {
    PRCL_DIV1 = 2'b00,
    PRCL_DIV2 = 2'b01,
    PRCL_DIV4 = 2'b10,
    PRCL_DIV8 = 2'b11
  } prcl_div_t;

  typedef enum logic {
    PRCL_CLR_IDLE = 1'b0,
    PRCL_CLR_ARMED = 1'b1
  } prcl_clr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prcl_bus_req_t;

endpackage

//--- prcl_top.sv
`timescale 1ns/10ps
`default_nettype none
module prcl_top #(
  parameter int CW = 16,
  parameter int NCH = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire prcl_pkg::prcl_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic [CW-1:0] i_mod_buf,
  input wire logic [NCH*CW-1:0] i_val_buf,
  input wire logic [NCH-1:0] i_override,
  input wire logic [NCH-1:0] i_override_val,
  output logic [NCH-1:0] o_pwm_out,
  output logic [CW-1:0] o_mod_active,
  output logic [NCH*CW-1:0] o_val_active,
  output logic [CW-1:0] o_count,
  output logic o_reload,
  output logic o_irq
);
  import prcl_pkg::*;

  prcl_div_t div_buf_reg;
  prcl_div_t div_act_reg;
  prcl_clr_t clr_reg;
  logic irq_en_reg;
  logic flag_reg;
  logic load_okay_reg;
  logic enable_reg;
  logic [3:0] load_frequency_select_buf_reg;
  logic [3:0] load_frequency_select_act_reg;
  logic [3:0] opp_cnt_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] mod_act_reg;
  logic [NCH*CW-1:0] val_act_reg;
  logic [PRCL_EV_W-1:0] ev_stat_reg;
  logic [PRCL_EV_W-1:0] ev_mask_reg;
  logic [PRCL_EV_W-1:0] ev_set;
  logic [NCH-1:0] pwm_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic tick;
  logic cnt_last;
  logic opp;
  logic reload;
  logic loaded;
  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_ctrlh;
  logic wr_stat;
  logic wr_mask;
  logic flag_clear;

  assign wr_ctrl = i_bus.wr && (i_bus.addr == PRCL_OFS_CTRL_LOW);
  assign rd_ctrl = i_bus.rd && (i_bus.addr == PRCL_OFS_CTRL_LOW);
  assign wr_ctrlh = i_bus.wr && (i_bus.addr == PRCL_OFS_CTRL_HIGH);
  assign wr_stat = i_bus.wr && (i_bus.addr == PRCL_OFS_IRQ_STATUS);
  assign wr_mask = i_bus.wr && (i_bus.addr == PRCL_OFS_IRQ_MASK);

  prcl_clk_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_run(enable_reg),
    .i_div_sel(div_act_reg),
    .o_tick(tick)
  );

  // A zero modulus wraps on every PWM clock so the counter can never run away.
  assign cnt_last = (mod_act_reg == '0) || (cnt_reg >= (mod_act_reg - {{(CW-1){1'b0}}, 1'b1}));
  assign opp = tick && cnt_last;
  assign reload = opp && (opp_cnt_reg == load_frequency_select_act_reg);
  assign loaded = reload && load_okay_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (!enable_reg) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_last ? '0 : cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opp_cnt_reg <= 4'h0;
      load_frequency_select_act_reg <= PRCL_LOAD_FREQUENCY_SELECT_RESET;
      load_frequency_select_buf_reg <= PRCL_LOAD_FREQUENCY_SELECT_RESET;
    end else begin
      if (!enable_reg) begin
        opp_cnt_reg <= 4'h0;
      end else if (opp) begin
        opp_cnt_reg <= reload ? 4'h0 : opp_cnt_reg + 4'h1;
      end
      if (reload) begin
        load_frequency_select_act_reg <= load_frequency_select_buf_reg;
      end
      if (wr_ctrlh) begin
        load_frequency_select_buf_reg <= i_bus.wdata[PRCL_BIT_LOAD_FREQUENCY_SELECT_HI:PRCL_BIT_LOAD_FREQUENCY_SELECT_LO];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_buf_reg <= prcl_div_t'(PRCL_CTRL_LOW_RESET[PRCL_BIT_DIV_HI:PRCL_BIT_DIV_LO]);
      irq_en_reg <= PRCL_CTRL_LOW_RESET[PRCL_BIT_IRQ_EN];
      enable_reg <= PRCL_CTRL_LOW_RESET[PRCL_BIT_ENABLE];
    end else if (wr_ctrl) begin
      div_buf_reg <= prcl_div_t'(i_bus.wdata[PRCL_BIT_DIV_HI:PRCL_BIT_DIV_LO]);
      irq_en_reg <= i_bus.wdata[PRCL_BIT_IRQ_EN];
      enable_reg <= i_bus.wdata[PRCL_BIT_ENABLE];
    end
  end

  // A write that lands on the reload cycle decides the bit for the next reload.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_okay_reg <= PRCL_CTRL_LOW_RESET[PRCL_BIT_LOAD_OKAY];
    end else if (wr_ctrl) begin
      load_okay_reg <= i_bus.wdata[PRCL_BIT_LOAD_OKAY];
    end else if (loaded) begin
      load_okay_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_act_reg <= PRCL_DIV1;
      mod_act_reg <= '0;
      val_act_reg <= '0;
    end else if (loaded) begin
      div_act_reg <= div_buf_reg;
      mod_act_reg <= i_mod_buf;
      val_act_reg <= i_val_buf;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_reg <= PRCL_CLR_IDLE;
    end else if (reload) begin
      clr_reg <= PRCL_CLR_IDLE;
    end else if (rd_ctrl && flag_reg) begin
      clr_reg <= PRCL_CLR_ARMED;
    end else if (wr_ctrl && !i_bus.wdata[PRCL_BIT_FLAG]) begin
      clr_reg <= PRCL_CLR_IDLE;
    end
  end

  assign flag_clear = wr_ctrl && !i_bus.wdata[PRCL_BIT_FLAG] && (clr_reg == PRCL_CLR_ARMED);

  // A reload in the same cycle as the clearing write keeps the flag set.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= PRCL_CTRL_LOW_RESET[PRCL_BIT_FLAG];
    end else if (reload) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign ev_set[PRCL_EV_RELOAD] = reload;
  assign ev_set[PRCL_EV_LOADED] = loaded;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ev_stat_reg <= '0;
    end else if (wr_stat) begin
      ev_stat_reg <= (ev_stat_reg & ~i_bus.wdata[PRCL_EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_reg <= ev_stat_reg | ev_set;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ev_mask_reg <= '0;
    end else if (wr_mask) begin
      ev_mask_reg <= i_bus.wdata[PRCL_EV_W-1:0];
    end
  end

  assign o_irq = (flag_reg && irq_en_reg) || (|(ev_stat_reg & ev_mask_reg));

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    always_comb begin
      if (i_override[ch]) begin
        pwm_next[ch] = i_override_val[ch];
      end else if (enable_reg) begin
        pwm_next[ch] = cnt_reg < val_act_reg[ch*CW +: CW];
      end else begin
        pwm_next[ch] = 1'b0;
      end
    end

    property p_pins_idle;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!enable_reg && !i_override[ch]) |=> !o_pwm_out[ch];
    endproperty
    a_pins_idle: assert property (p_pins_idle) else $error("disabled pin not inactive");
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pwm_out <= '0;
    end else begin
      o_pwm_out <= pwm_next;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        PRCL_OFS_CTRL_LOW: begin
          rdata_next[PRCL_BIT_DIV_HI:PRCL_BIT_DIV_LO] = div_buf_reg;
          rdata_next[PRCL_BIT_IRQ_EN] = irq_en_reg;
          rdata_next[PRCL_BIT_FLAG] = flag_reg;
          rdata_next[PRCL_BIT_RSVD_HI:PRCL_BIT_RSVD_LO] = 2'b00;
          rdata_next[PRCL_BIT_LOAD_OKAY] = load_okay_reg;
          rdata_next[PRCL_BIT_ENABLE] = enable_reg;
        end
        PRCL_OFS_CTRL_HIGH: rdata_next[PRCL_BIT_LOAD_FREQUENCY_SELECT_HI:PRCL_BIT_LOAD_FREQUENCY_SELECT_LO] = load_frequency_select_buf_reg;
        PRCL_OFS_IRQ_STATUS: rdata_next[PRCL_EV_W-1:0] = ev_stat_reg;
        PRCL_OFS_IRQ_MASK: rdata_next[PRCL_EV_W-1:0] = ev_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_mod_active = mod_act_reg;
  assign o_val_active = val_act_reg;
  assign o_count = cnt_reg;
  assign o_reload = reload;

  property p_reload_sets_flag;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      reload |=> flag_reg;
  endproperty
  a_reload_sets_flag: assert property (p_reload_sets_flag) else $error("reload left flag clear");

  property p_reload_irq;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (reload && irq_en_reg && !wr_ctrl) |=> o_irq;
  endproperty
  a_reload_irq: assert property (p_reload_irq) else $error("enabled reload raised no interrupt");

  property p_no_irq;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!irq_en_reg && ((ev_stat_reg & ev_mask_reg) == '0)) |-> !o_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled");

  property p_div_applied;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      loaded |=> div_act_reg == $past(div_buf_reg);
  endproperty
  a_div_applied: assert property (p_div_applied) else $error("prescaler not applied");

  property p_div_held;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !loaded |=> $stable(div_act_reg) && $stable(mod_act_reg);
  endproperty
  a_div_held: assert property (p_div_held) else $error("active value moved off reload");

  property p_load_okay_self_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (loaded && !wr_ctrl) |=> !load_okay_reg;
  endproperty
  a_load_okay_self_clear: assert property (p_load_okay_self_clear) else $error("load-okay not cleared");

  property p_flag_needs_read;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (flag_reg && clr_reg == PRCL_CLR_IDLE) |=> flag_reg;
  endproperty
  a_flag_needs_read: assert property (p_flag_needs_read) else $error("flag cleared w/o read");

  property p_reload_disarms;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      reload ##1 (wr_ctrl && !i_bus.wdata[PRCL_BIT_FLAG]) |=> flag_reg;
  endproperty
  a_reload_disarms: assert property (p_reload_disarms) else $error("stale clear took effect");

  property p_flag_w1_noop;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!flag_reg && !reload) |=> !flag_reg;
  endproperty
  a_flag_w1_noop: assert property (p_flag_w1_noop) else $error("flag set without reload");

  property p_read_ctrl;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      rd_ctrl |=> (o_rdata[PRCL_BIT_RSVD_HI:PRCL_BIT_RSVD_LO] == 2'b00)
        && (o_rdata[PRCL_BIT_DIV_HI:PRCL_BIT_DIV_LO] == $past(div_buf_reg));
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong");

  c_reload: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) loaded);
  c_flag_cleared: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) flag_clear);
  c_clear_blocked: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (clr_reg == PRCL_CLR_ARMED) && reload);

endmodule
`default_nettype wire

//--- prcl_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module prcl_top_tb_top;
  import prcl_pkg::*;
  logic i_clk_sys;
  logic i_rst_n;
  prcl_bus_req_t bus;
  logic [7:0] rdata;
  logic [15:0] mod_buf;
  logic [95:0] val_buf;
  logic [5:0] ovr;
  logic [5:0] ovr_val;
  logic [5:0] pwm_out;
  logic [15:0] mod_act;
  logic [95:0] val_act;
  logic [15:0] count;
  logic reload;
  logic irq;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] d;
  int n;

  prcl_top u_dut (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_mod_buf(mod_buf),
    .i_val_buf(val_buf),
    .i_override(ovr),
    .i_override_val(ovr_val),
    .o_pwm_out(pwm_out),
    .o_mod_active(mod_act),
    .o_val_active(val_act),
    .o_count(count),
    .o_reload(reload),
    .o_irq(irq)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic finish_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Stops the run at cycle 20000 if reload waits keep running out to their 2000-cycle limit.
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [95:0] e, input logic [95:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge i_clk_sys);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk_sys);
    bus <= '0;
    #1;
    v = rdata;
  endtask

  // Returns in the reload cycle, with the number of cycles waited.
  task automatic wait_rl(output int k);
    k = 0;
    do begin
      @(negedge i_clk_sys);
      k++;
    end while (reload !== 1'b1 && k < 2000);
    chk("reload_seen", 96'h1, 96'(reload));
  endtask

  task automatic settle();
    repeat (2) @(negedge i_clk_sys);
  endtask

  task automatic t_reset();
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("ctrl_low", 96'h00, 96'(d));
    rd(PRCL_OFS_CTRL_HIGH, d);
    chk("ctrl_high", 96'h00, 96'(d));
    chk("irq", 96'h0, 96'(irq));
    chk("pins", 96'h0, 96'(pwm_out));
  endtask

  task automatic t_bits();
    wr(PRCL_OFS_CTRL_LOW, 8'h1C);
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("reserved_flag", 96'h00, 96'(d));
    wr(PRCL_OFS_CTRL_LOW, 8'hC0);
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("div_readback", 96'hC0, 96'(d));
    wr(PRCL_OFS_CTRL_LOW, 8'h00);
  endtask

  task automatic t_divide();
    mod_buf <= 16'h0004;
    val_buf <= 96'hFFFF_0000;
    for (int s = 0; s < 4; s++) begin
      wr(PRCL_OFS_CTRL_LOW, {s[1:0], 6'b00_0011});
      wait_rl(n);
      rd(PRCL_OFS_CTRL_LOW, d);
      chk("div_sel", 96'(s), 96'(d[7:6]));
      chk("load_okay_auto", 96'h0, 96'(d[1]));
      wait_rl(n);
      wait_rl(n);
      chk("gap", 96'(4 << s), 96'(n));
    end
    chk("mod_active", 96'h4, 96'(mod_act));
    chk("val_active", 96'hFFFF_0000, val_act);
    chk("pins_run", 96'h02, 96'(pwm_out));
    wr(PRCL_OFS_CTRL_LOW, 8'h01);
    repeat (3) wait_rl(n);
    chk("gap_no_load", 96'd32, 96'(n));
    wait_rl(n);
    wr(PRCL_OFS_CTRL_LOW, 8'h03);
    mod_buf <= 16'h0006;
    wr(PRCL_OFS_CTRL_LOW, 8'h01);
    repeat (2) wait_rl(n);
    chk("mod_cancel", 96'h4, 96'(mod_act));
  endtask

  task automatic t_load_frequency_select();
    wr(PRCL_OFS_CTRL_HIGH, 8'h10);
    rd(PRCL_OFS_CTRL_HIGH, d);
    chk("load_frequency_select_readback", 96'h10, 96'(d));
    repeat (3) wait_rl(n);
    chk("gap_load_frequency_select", 96'd64, 96'(n));
    wr(PRCL_OFS_CTRL_HIGH, 8'h00);
    repeat (3) wait_rl(n);
    chk("gap_ldfq0", 96'd32, 96'(n));
  endtask

  task automatic t_flag();
    wait_rl(n);
    settle();
    chk("irq_disabled", 96'h0, 96'(irq));
    wr(PRCL_OFS_CTRL_LOW, 8'h21);
    settle();
    chk("irq_enabled", 96'h1, 96'(irq));
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("flag_set", 96'h1, 96'(d[4]));
    wr(PRCL_OFS_CTRL_LOW, 8'h21);
    settle();
    chk("irq_cleared", 96'h0, 96'(irq));
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("flag_cleared", 96'h0, 96'(d[4]));
    wait_rl(n);
    rd(PRCL_OFS_CTRL_LOW, d);
    wait_rl(n);
    wr(PRCL_OFS_CTRL_LOW, 8'h21);
    rd(PRCL_OFS_CTRL_LOW, d);
    chk("flag_kept", 96'h1, 96'(d[4]));
  endtask

  task automatic t_status();
    wr(PRCL_OFS_CTRL_LOW, 8'h00);
    settle();
    rd(PRCL_OFS_IRQ_STATUS, d);
    chk("status", 96'h03, 96'(d));
    chk("irq_masked", 96'h0, 96'(irq));
    wr(PRCL_OFS_IRQ_MASK, 8'h01);
    settle();
    chk("irq_reload_ev", 96'h1, 96'(irq));
    wr(PRCL_OFS_IRQ_STATUS, 8'h01);
    rd(PRCL_OFS_IRQ_STATUS, d);
    chk("status_w1c", 96'h02, 96'(d));
    chk("irq_after_w1c", 96'h0, 96'(irq));
    wr(PRCL_OFS_IRQ_MASK, 8'h02);
    settle();
    chk("irq_loaded_ev", 96'h1, 96'(irq));
    wr(PRCL_OFS_IRQ_STATUS, 8'h02);
    settle();
    chk("irq_off", 96'h0, 96'(irq));
    rd(8'h7F, d);
    chk("unmapped", 96'h00, 96'(d));
  endtask

  task automatic t_override();
    ovr <= 6'h05;
    ovr_val <= 6'h3F;
    settle();
    chk("pins_override", 96'h05, 96'(pwm_out));
    chk("count_idle", 96'h0, 96'(count));
    ovr <= 6'h00;
  endtask

  task automatic t_rereset();
    wr(PRCL_OFS_CTRL_LOW, 8'hE3);
    wr(PRCL_OFS_CTRL_HIGH, 8'hF0);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset();
  endtask

  initial begin
    i_rst_n = 1'b0;
    bus = '0;
    mod_buf = 16'h0000;
    val_buf = 96'h0;
    ovr = 6'h00;
    ovr_val = 6'h00;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset();
    t_bits();
    t_divide();
    t_load_frequency_select();
    t_flag();
    t_status();
    t_override();
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
